// ==== tb_vmep_precheck.sv ====
// Self-checking testbench for the guest-entry precheck unit
`timescale 1ns/10ps

// Compare a value with its expectation and count the outcome
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end

module tb_vmep_precheck;
	import vmep_pkg::*;

	// Clock, reset and APB signals
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [3:0]        pstrb;
	logic              pready;
	logic [31:0]       prdata;
	logic              pslverr;
	// Last read answer and bookkeeping
	logic [31:0]       rdat;
	logic              rerr;
	logic [31:0]       base [16];
	int                n_mismatch;
	int                check_count;

	vmep_precheck u_vmep_precheck (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pstrb   (pstrb),
		.pready  (pready),
		.prdata  (prdata),
		.pslverr (pslverr)
	);

	// 125 MHz clock
	always #4 pclk = ~pclk;

	// Verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// One APB transfer: setup, then access held until pready
	task automatic xf(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat    = prdata;
		rerr    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Load two registers, start an attempt, check RESULT, restore
	task automatic run(input logic [3:0] i1, input logic [31:0] v1, input logic [3:0] i2,
		input logic [31:0] v2, input vmep_outcome_type o, input logic [7:0] e);
		int          n;
		logic [31:0] ex;
		ex = {16'h0, e, 2'b00, o == OUT_ZF, o == OUT_CF, 1'b0, o};
		xf(1'b1, {i1, 2'b00}, v1);
		xf(1'b1, {i2, 2'b00}, v2);
		xf(1'b1, {IDX_CTRL, 2'b00}, 32'h1);
		n = 0;
		// Poll until the sequencer is idle, bounded
		do begin
			xf(1'b0, {IDX_RESULT, 2'b00}, 32'h0);
			n++;
		end while (rdat[B_BUSY] !== 1'b0 && n < 20);
		`CHK("result", ex, rdat)
		xf(1'b1, {i1, 2'b00}, base[i1]);
		xf(1'b1, {i2, 2'b00}, base[i2]);
	endtask

	// Control-field case on a clean structure: bad or good
	task automatic ctl(input logic [3:0] i1, input logic [31:0] v1, input logic [3:0] i2,
		input logic [31:0] v2, input logic bad);
		if (bad) begin
			run(i1, v1, i2, v2, OUT_ZF, ERR_CONTROLS);
		end else begin
			run(i1, v1, i2, v2, OUT_PASS, ERR_NONE);
		end
	endtask

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		test_done();
	end

	// Main sequence
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hf;
		n_mismatch = 0;
		check_count = 0;
		// Clean configuration: present, first entry, controls legal
		foreach (base[i]) base[i] = 32'h0;
		base[IDX_STATE] = 32'h0000_0010;
		base[IDX_PIN]   = 32'h0000_0016;
		base[IDX_PROC]  = 32'h0000_0002;
		base[IDX_VPRIO] = 32'h0000_0010;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values of all configuration registers
		for (int i = CFG_FIRST; i <= CFG_LAST; i++) begin
			xf(1'b0, {i[3:0], 2'b00}, 32'h0);
			`CHK("cfg reset", CFG_RST, rdat)
			xf(1'b1, {i[3:0], 2'b00}, base[i]);
		end
		// Basic checks, order and first failure
		run(IDX_STATE, 32'h1d, IDX_STATE, 32'h1d, OUT_UD, ERR_NONE);
		run(IDX_STATE, 32'h0c, IDX_STATE, 32'h0c, OUT_GP, ERR_NONE);
		run(IDX_STATE, 32'h00, IDX_STATE, 32'h00, OUT_CF, ERR_NONE);
		run(IDX_STATE, 32'h30, IDX_STATE, 32'h30, OUT_CF, ERR_NONE);
		run(IDX_STATE, 32'hd0, IDX_STATE, 32'hd0, OUT_ZF, ERR_BLOCKED);
		run(IDX_STATE, 32'h90, IDX_STATE, 32'h90, OUT_ZF, ERR_NOT_CLEAR);
		run(IDX_STATE, 32'h12, IDX_STATE, 32'h12, OUT_ZF, ERR_NOT_LAUNCHED);
		run(IDX_STATE, 32'h92, IDX_STATE, 32'h92, OUT_PASS, ERR_NONE);
		run(IDX_STATE, 32'h00, IDX_PIN, 32'h06, OUT_CF, ERR_NONE);
		run(IDX_STATE, 32'h90, IDX_PIN, 32'h06, OUT_ZF, ERR_NOT_CLEAR);
		// Control fields
		ctl(IDX_PIN, 32'h06, IDX_PIN, 32'h06, 1'b1);
		ctl(IDX_PIN, 32'h96, IDX_PIN, 32'h96, 1'b1);
		ctl(IDX_PROC, 32'h0, IDX_PROC, 32'h0, 1'b1);
		ctl(IDX_PROC, 32'h3, IDX_PROC, 32'h3, 1'b1);
		ctl(IDX_PROC, 32'h8000_0002, IDX_PROC2, 32'h2, 1'b1);
		ctl(IDX_PROC2, 32'h2, IDX_PROC2, 32'h2, 1'b0);
		ctl(IDX_TCOUNT, 32'h4, IDX_TCOUNT, 32'h4, 1'b0);
		ctl(IDX_TCOUNT, 32'h5, IDX_TCOUNT, 32'h5, 1'b1);
		ctl(IDX_PROC, 32'h0200_0002, IDX_IOA, 32'h1000, 1'b0);
		ctl(IDX_PROC, 32'h0200_0002, IDX_IOB, 32'h800, 1'b1);
		ctl(IDX_IOA, 32'h1, IDX_REGMAP, 32'h1, 1'b0);
		ctl(IDX_PROC, 32'h1000_0002, IDX_REGMAP, 32'h10, 1'b1);
		ctl(IDX_PROC, 32'h0020_0002, IDX_VAPIC, 32'h4, 1'b1);
		ctl(IDX_PROC, 32'h8000_0002, IDX_PROC2, 32'h1, 1'b0);
		xf(1'b1, {IDX_ACCESS, 2'b00}, 32'h100);
		ctl(IDX_PROC, 32'h8000_0002, IDX_PROC2, 32'h1, 1'b1);
		xf(1'b1, {IDX_ACCESS, 2'b00}, 32'h0);
		// Delivery control masks both threshold checks, access control only the low one
		xf(1'b1, {IDX_THRESH, 2'b00}, 32'h12);
		ctl(IDX_PROC, 32'h8020_0002, IDX_PROC2, 32'h200, 1'b0);
		ctl(IDX_PROC, 32'h0020_0002, IDX_PROC2, 32'h200, 1'b1);
		xf(1'b1, {IDX_THRESH, 2'b00}, 32'h2);
		ctl(IDX_PROC, 32'h8020_0002, IDX_PROC2, 32'h1, 1'b0);
		xf(1'b1, {IDX_THRESH, 2'b00}, 32'h0);
		ctl(IDX_PROC, 32'h0020_0002, IDX_THRESH, 32'h10, 1'b1);
		ctl(IDX_PROC, 32'h0020_0002, IDX_THRESH, 32'h2, 1'b1);
		ctl(IDX_PROC, 32'h0020_0002, IDX_THRESH, 32'h1, 1'b0);
		ctl(IDX_PIN, 32'h36, IDX_PIN, 32'h36, 1'b1);
		ctl(IDX_PIN, 32'h3e, IDX_PIN, 32'h3e, 1'b0);
		ctl(IDX_PROC, 32'h0040_0002, IDX_PROC, 32'h0040_0002, 1'b1);
		// Priority bytes 3:1 cleared once the early control checks pass, though the threshold check fails
		xf(1'b1, {IDX_VPRIO, 2'b00}, 32'habcd_ef10);
		ctl(IDX_PROC, 32'h0020_0002, IDX_THRESH, 32'h10, 1'b1);
		xf(1'b0, {IDX_VPRIO, 2'b00}, 32'h0);
		`CHK("vprio cleared", 32'h0000_0010, rdat)
		// Byte lanes: only lane 1 written
		pstrb <= 4'h2;
		xf(1'b1, {IDX_VPRIO, 2'b00}, 32'hffff_ffff);
		pstrb <= 4'hf;
		xf(1'b0, {IDX_VPRIO, 2'b00}, 32'h0);
		`CHK("vprio lane", 32'h0000_ff10, rdat)
		// Unmapped and misaligned places, read-only result
		xf(1'b0, 6'h38, 32'h0);
		`CHK("unmapped err", 1'b1, rerr)
		`CHK("unmapped data", 32'h0, rdat)
		xf(1'b0, 6'h05, 32'h0);
		`CHK("misaligned err", 1'b1, rerr)
		xf(1'b1, {IDX_RESULT, 2'b00}, 32'hffff_ffff);
		xf(1'b0, {IDX_RESULT, 2'b00}, 32'h0);
		`CHK("result ro", {16'h0, ERR_CONTROLS, 8'h20 | 8'(OUT_ZF)}, rdat)
		test_done();
	end

endmodule // tb_vmep_precheck

// ==== vmep_pkg.sv ====
// Constants, register map and types for the guest-entry precheck block
package vmep_pkg;

	// APB geometry
	localparam int          ADDR_W   = 6;
	localparam logic [1:0]  ALIGN_OK = 2'h0;

	// Register indices (byte address = 4 * index)
	localparam logic [3:0]  IDX_CTRL   = 4'h0;
	localparam logic [3:0]  IDX_STATE  = 4'h1;
	localparam logic [3:0]  IDX_PIN    = 4'h2;
	localparam logic [3:0]  IDX_PROC   = 4'h3;
	localparam logic [3:0]  IDX_PROC2  = 4'h4;
	localparam logic [3:0]  IDX_TCOUNT = 4'h5;
	localparam logic [3:0]  IDX_IOA    = 4'h6;
	localparam logic [3:0]  IDX_IOB    = 4'h7;
	localparam logic [3:0]  IDX_REGMAP = 4'h8;
	localparam logic [3:0]  IDX_VAPIC  = 4'h9;
	localparam logic [3:0]  IDX_ACCESS = 4'ha;
	localparam logic [3:0]  IDX_THRESH = 4'hb;
	localparam logic [3:0]  IDX_VPRIO  = 4'hc;
	localparam logic [3:0]  IDX_RESULT = 4'hd;
	localparam int          CFG_FIRST  = 1;
	localparam int          CFG_LAST   = 12;
	localparam logic [31:0] CFG_RST    = 32'h0000_0000;

	// Control register and processor state fields
	localparam int B_START    = 0;
	localparam int B_MODE     = 0;
	localparam int B_KIND     = 1;
	localparam int PRIV_LSB   = 2;
	localparam int PRIV_MSB   = 3;
	localparam int B_PRESENT  = 4;
	localparam int B_SHADOW   = 5;
	localparam int B_BLOCK    = 6;
	localparam int B_LAUNCHED = 7;

	// Execution control bit positions
	localparam int B_NMI_EXIT = 3;
	localparam int B_VNMI     = 5;
	localparam int B_PRIO_SH  = 21;
	localparam int B_NMI_WIN  = 22;
	localparam int B_IO       = 25;
	localparam int B_REGMAP   = 28;
	localparam int B_ACT_SEC  = 31;
	localparam int B_VACC     = 0;
	localparam int B_VID      = 9;

	// Capability settings: bits forced to one, bits allowed to be one, target count limit
	localparam logic [31:0] PIN_MUST1   = 32'h0000_0016;
	localparam logic [31:0] PIN_MAY1    = 32'h0000_007f;
	localparam logic [31:0] PROC_MUST1  = 32'h0000_0002;
	localparam logic [31:0] PROC_MAY1   = 32'hffff_fffe;
	localparam logic [31:0] PROC2_MAY1  = 32'h0000_0201;
	localparam logic [31:0] TARGET_MAX  = 32'h0000_0004;

	// Address and threshold field masks
	localparam logic [31:0] PAGE_MASK   = 32'h0000_0fff;
	localparam logic [31:0] THR_HI_MASK = 32'hffff_fff0;
	localparam logic [31:0] VPRIO_KEEP  = 32'h0000_00ff;
	localparam int          THR_LO_MSB  = 3;
	localparam int          VPRIO_LSB   = 4;
	localparam int          VPRIO_MSB   = 7;

	// Result register fields
	localparam int OUT_LSB = 0;
	localparam int OUT_MSB = 2;
	localparam int B_BUSY  = 3;
	localparam int B_CF    = 4;
	localparam int B_ZF    = 5;
	localparam int ERR_LSB = 8;
	localparam int ERR_MSB = 15;

	// Error numbers (values arbitrary)
	localparam logic [7:0] ERR_NONE         = 8'h00;
	localparam logic [7:0] ERR_BLOCKED      = 8'h01;
	localparam logic [7:0] ERR_NOT_CLEAR    = 8'h02;
	localparam logic [7:0] ERR_NOT_LAUNCHED = 8'h03;
	localparam logic [7:0] ERR_CONTROLS     = 8'h04;

	// Check sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_BASIC, ST_CTRL} vmep_state_type;

	// Outcome of one entry attempt
	typedef enum logic [2:0] {
		OUT_NONE, OUT_PASS, OUT_UD, OUT_GP, OUT_CF, OUT_ZF
	} vmep_outcome_type;

endpackage

// ==== vmep_precheck.sv ====
// Guest-entry precheck unit with APB register access
`timescale 1ns/10ps

module vmep_precheck
	import vmep_pkg::*;
(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB request
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	// APB answer
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr
);

	// Sequencer and outcome state
	vmep_state_type   st_q, st_d;          // Check phase
	vmep_outcome_type out_q, out_d;        // Last outcome
	logic             cf_q, cf_d;          // Carry flag result
	logic             zf_q, zf_d;          // Zero flag result
	logic [7:0]       err_q, err_d;        // Instruction error number
	logic [31:0]      prdata_q;            // Read data holder
	logic             pslverr_q;           // Error answer holder
	logic [31:0]      cfg_q [CFG_FIRST:CFG_LAST]; // Software fields

	// Bus decode
	wire  [3:0]  idx     = paddr[ADDR_W-1:2];
	wire         mapped  = (paddr[1:0] == ALIGN_OK) && (idx <= IDX_RESULT);
	wire         setup   = psel && !penable;
	wire         wr_en   = psel && penable && pwrite && mapped && (idx != IDX_RESULT);
	wire  [31:0] wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	wire         busy    = (st_q != ST_IDLE);
	wire         start   = wr_en && (idx == IDX_CTRL) && pstrb[0] && pwdata[B_START] && !busy;

	// Field views
	wire  [31:0] state_w = cfg_q[IDX_STATE];
	wire  [31:0] pin     = cfg_q[IDX_PIN];
	wire  [31:0] proc    = cfg_q[IDX_PROC];
	wire  [31:0] thr     = cfg_q[IDX_THRESH];
	wire  [31:0] vprio   = cfg_q[IDX_VPRIO];

	// Basic checks
	wire mode_bad   = state_w[B_MODE];
	wire priv_bad   = (state_w[PRIV_MSB:PRIV_LSB] != 2'h0);
	wire no_struct  = !state_w[B_PRESENT];
	wire shadow     = state_w[B_SHADOW];
	wire blocked    = state_w[B_BLOCK];
	wire first_bad  = !state_w[B_KIND] && state_w[B_LAUNCHED];
	wire sub_bad    = state_w[B_KIND] && !state_w[B_LAUNCHED];
	wire pre_ok     = !mode_bad && !priv_bad && !no_struct && !shadow;
	wire basic_ok   = pre_ok && !blocked && !first_bad && !sub_bad;

	// Secondary controls only count when activation is on and supported
	wire         act_sec = proc[B_ACT_SEC] && PROC_MAY1[B_ACT_SEC];
	wire  [31:0] sec     = act_sec ? cfg_q[IDX_PROC2] : CFG_RST;

	// Reserved bit checks against capability settings
	wire pin_bad  = ((pin & PIN_MUST1) != PIN_MUST1) || ((pin & ~PIN_MAY1) != CFG_RST);
	wire proc_bad = ((proc & PROC_MUST1) != PROC_MUST1)
		|| ((proc & ~PROC_MAY1) != CFG_RST);
	wire sec_bad  = act_sec && ((sec & ~PROC2_MAY1) != CFG_RST);

	// Target count limit
	wire cnt_bad  = (cfg_q[IDX_TCOUNT] > TARGET_MAX);

	// Bitmap address alignment
	wire io_bad   = proc[B_IO]
		&& (((cfg_q[IDX_IOA] | cfg_q[IDX_IOB]) & PAGE_MASK) != CFG_RST);
	wire regmap_bad = proc[B_REGMAP] && ((cfg_q[IDX_REGMAP] & PAGE_MASK) != CFG_RST);

	// Page address alignment
	wire prio_sh  = proc[B_PRIO_SH];
	wire acc_on   = sec[B_VACC];
	wire vid_on   = sec[B_VID];
	wire vapic_bad = prio_sh && ((cfg_q[IDX_VAPIC] & PAGE_MASK) != CFG_RST);
	wire acc_bad  = acc_on && ((cfg_q[IDX_ACCESS] & PAGE_MASK) != CFG_RST);

	// Checks that gate the priority clear
	wire early_ok = !(pin_bad || proc_bad || sec_bad || cnt_bad || io_bad || regmap_bad
		|| vapic_bad);
	wire clr_vprio = (st_q == ST_CTRL) && early_ok && prio_sh;

	// Threshold checks
	wire thr_hi_bad = prio_sh && !vid_on && ((thr & THR_HI_MASK) != CFG_RST);
	wire thr_lo_bad = prio_sh && !acc_on && !vid_on
		&& (thr[THR_LO_MSB:0] > vprio[VPRIO_MSB:VPRIO_LSB]);

	// NMI control dependencies
	wire nmi_bad  = (pin[B_VNMI] && !pin[B_NMI_EXIT])
		|| (proc[B_NMI_WIN] && !pin[B_VNMI]);

	// Any control failure yields one shared cause
	wire ctrl_bad = !early_ok || acc_bad || thr_hi_bad || thr_lo_bad || nmi_bad;

	// Read data selection
	wire [31:0] result_w = {16'h0000, err_q, 2'h0, zf_q, cf_q, busy, out_q};
	wire [31:0] rdata_w  = (idx == IDX_RESULT) ? result_w
		: (idx == IDX_CTRL) ? {28'h0000000, busy, 3'h0}
		: cfg_q[idx];

	// APB answers with no wait state
	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	// Software fields, byte-lane writes, hardware clear of priority bytes
	for (genvar i = CFG_FIRST; i <= CFG_LAST; i++) begin : g_cfg
		wire sel_w = wr_en && (idx == 4'(i));
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cfg_q[i] <= CFG_RST;
			end else if (sel_w) begin
				cfg_q[i] <= (cfg_q[i] & ~wmask) | (pwdata & wmask);
			end else if ((i == int'(IDX_VPRIO)) && clr_vprio) begin
				cfg_q[i] <= cfg_q[i] & VPRIO_KEEP;
			end
		end
	end

	// Read data and error captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= CFG_RST;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q  <= (mapped && !pwrite) ? rdata_w : CFG_RST;
			pslverr_q <= !mapped;
		end
	end

	// Sequencer: basic checks, then control checks
	always_comb begin
		st_d  = st_q;
		out_d = out_q;
		cf_d  = cf_q;
		zf_d  = zf_q;
		err_d = err_q;
		case (st_q)
			ST_IDLE: begin
				// New attempt clears the previous outcome
				if (start) begin
					st_d  = ST_BASIC;
					out_d = OUT_NONE;
					cf_d  = 1'b0;
					zf_d  = 1'b0;
					err_d = ERR_NONE;
				end
			end
			ST_BASIC: begin
				// Fixed priority, first failure wins
				st_d = ST_IDLE;
				if (mode_bad) begin
					out_d = OUT_UD;
				end else if (priv_bad) begin
					out_d = OUT_GP;
				end else if (no_struct || shadow) begin
					out_d = OUT_CF;
					cf_d  = 1'b1;
				end else if (blocked) begin
					out_d = OUT_ZF;
					zf_d  = 1'b1;
					err_d = ERR_BLOCKED;
				end else if (first_bad) begin
					out_d = OUT_ZF;
					zf_d  = 1'b1;
					err_d = ERR_NOT_CLEAR;
				end else if (sub_bad) begin
					out_d = OUT_ZF;
					zf_d  = 1'b1;
					err_d = ERR_NOT_LAUNCHED;
				end else begin
					st_d = ST_CTRL;
				end
			end
			ST_CTRL: begin
				// Controls judged only after a basic pass
				st_d = ST_IDLE;
				if (ctrl_bad) begin
					out_d = OUT_ZF;
					zf_d  = 1'b1;
					err_d = ERR_CONTROLS;
				end else begin
					out_d = OUT_PASS;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q  <= ST_IDLE;
			out_q <= OUT_NONE;
			cf_q  <= 1'b0;
			zf_q  <= 1'b0;
			err_q <= ERR_NONE;
		end else begin
			st_q  <= st_d;
			out_q <= out_d;
			cf_q  <= cf_d;
			zf_q  <= zf_d;
			err_q <= err_d;
		end
	end

	// Checks on the sequencer
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Accepted start and the two check phases
	sequence s_start;
		(st_q == ST_IDLE) && start;
	endsequence
	sequence s_basic_then_end;
		(st_q == ST_BASIC) ##1 ((st_q == ST_CTRL) || (st_q == ST_IDLE));
	endsequence

	a_phase_order: assert property (
		s_start |=> s_basic_then_end
	) else $error("check phases out of order");

	a_mode_fault: assert property (
		(st_q == ST_BASIC) && mode_bad |=> (out_q == OUT_UD) && !cf_q && !zf_q
	) else $error("mode check did not fault");

	a_priv_fault: assert property (
		(st_q == ST_BASIC) && !mode_bad && priv_bad |=> (out_q == OUT_GP)
	) else $error("privilege check did not fault");

	a_carry_fail: assert property (
		(st_q == ST_BASIC) && !mode_bad && !priv_bad && (no_struct || shadow)
		|=> cf_q && (out_q == OUT_CF) && (err_q == ERR_NONE)
	) else $error("structure check did not set carry");

	a_block_first: assert property (
		(st_q == ST_BASIC) && pre_ok && blocked |=> zf_q && (err_q == ERR_BLOCKED)
	) else $error("blocking not reported first");

	a_launch_clear: assert property (
		(st_q == ST_BASIC) && pre_ok && !blocked && first_bad
		|=> zf_q && (err_q == ERR_NOT_CLEAR)
	) else $error("first entry launch state missed");

	a_launch_set: assert property (
		(st_q == ST_BASIC) && pre_ok && !blocked && sub_bad
		|=> zf_q && (err_q == ERR_NOT_LAUNCHED)
	) else $error("subsequent entry launch state missed");

	a_ctrl_fail: assert property (
		(st_q == ST_BASIC) && basic_ok ##1 ctrl_bad
		|=> zf_q && (out_q == OUT_ZF) && (err_q == ERR_CONTROLS)
	) else $error("control failure not reported");

	a_count_limit: assert property (
		(st_q == ST_CTRL) && cnt_bad |=> (out_q == OUT_ZF)
	) else $error("target count over limit passed");

	a_prio_clear: assert property (
		clr_vprio && !(wr_en && (idx == IDX_VPRIO))
		|=> ((cfg_q[IDX_VPRIO] & ~VPRIO_KEEP) == CFG_RST)
	) else $error("priority bytes not cleared");

	// Any return to idle leaves one consistent outcome behind
	a_one_outcome: assert property (
		(st_q != ST_IDLE) ##1 (st_q == ST_IDLE) |-> (out_q != OUT_NONE)
		&& ((out_q == OUT_CF) == cf_q) && ((out_q == OUT_ZF) == zf_q)
	) else $error("attempt without single outcome");

	// Control failure as seen in the result fields
	sequence s_ctrl_fail;
		zf_q && !cf_q && (out_q == OUT_ZF) && (err_q == ERR_CONTROLS);
	endsequence

	a_shadow_carry: assert property (
		(st_q == ST_BASIC) && !mode_bad && !priv_bad && !no_struct && shadow
		|=> cf_q && !zf_q && (out_q == OUT_CF)
	) else $error("shadow structure did not set carry");

	a_basic_gate: assert property (
		(st_q == ST_BASIC) && !basic_ok |=> (st_q == ST_IDLE)
	) else $error("controls checked after basic failure");

	a_pin_reserved: assert property (
		(st_q == ST_CTRL) && pin_bad |=> s_ctrl_fail
	) else $error("pin control reserved bits passed");

	a_proc_reserved: assert property (
		(st_q == ST_CTRL) && proc_bad |=> s_ctrl_fail
	) else $error("primary control reserved bits passed");

	a_sec_reserved: assert property (
		(st_q == ST_CTRL) && sec_bad |=> s_ctrl_fail
	) else $error("secondary control reserved bits passed");

	a_sec_inactive: assert property (
		(st_q == ST_CTRL) && !proc[B_ACT_SEC] |-> !acc_on && !vid_on && !sec_bad
	) else $error("inactive secondary controls took effect");

	a_bitmap_align: assert property (
		(st_q == ST_CTRL) && (io_bad || regmap_bad) |=> s_ctrl_fail
	) else $error("misaligned bitmap address passed");

	a_page_align: assert property (
		(st_q == ST_CTRL) && (vapic_bad || acc_bad) |=> s_ctrl_fail
	) else $error("misaligned page address passed");

	a_thresh_limit: assert property (
		(st_q == ST_CTRL) && (thr_hi_bad || thr_lo_bad) |=> s_ctrl_fail
	) else $error("threshold check passed wrongly");

	a_nmi_depend: assert property (
		(st_q == ST_CTRL) && nmi_bad |=> s_ctrl_fail
	) else $error("nmi control dependency passed");

	a_ctrl_pass: assert property (
		(st_q == ST_CTRL) && !ctrl_bad
		|=> (out_q == OUT_PASS) && !cf_q && !zf_q && (err_q == ERR_NONE)
	) else $error("clean controls did not pass");

endmodule // vmep_precheck
